// ---- src/osc_lock_pkg.sv ----
// Purpose: constants for the oscillator lock and status controller
// Assumes: 8-bit byte address, 32-bit data, one aligned word per register
// Notes: counts are defaults only, the module takes them as parameters
package osc_lock_pkg;
	// register byte offsets
	localparam logic [7:0] fll_control_first = 8'h00;
	localparam logic [7:0] fll_control_second = 8'h04;
	localparam logic [7:0] fll_multiplier = 8'h08;
	localparam logic [7:0] fll_value_reg = 8'h0c;
	localparam logic [7:0] fll_status_reg = 8'h10;
	localparam logic [7:0] pll_control_first = 8'h20;
	localparam logic [7:0] pll_control_second = 8'h24;
	localparam logic [7:0] pll_ratio_reg = 8'h28;
	localparam logic [7:0] pll_status_reg = 8'h2c;
	localparam logic [7:0] int_flag_reg = 8'h30;
	localparam logic [7:0] int_mask_reg = 8'h34;
	// fll status bit positions
	localparam int fst_ready = 0;
	localparam int fst_coarse = 1;
	localparam int fst_fine = 2;
	localparam int fst_locked = 3;
	localparam int fst_sync_busy = 4;
	localparam int fst_settling = 5;
	localparam int fst_corrupt = 6;
	// control bit positions
	localparam int ctl_enable = 0;
	localparam int ctl_mode = 0;
	localparam int ctl_lose_lock_after_wake = 1;
	localparam int ctl_lock_bypass = 0;
	localparam int ctl_wake_up_fast = 1;
	// pll status bit positions
	localparam int pst_active = 0;
	localparam int pst_locked = 1;
	localparam int pst_ldrto = 2;
	// interrupt flag positions
	localparam int irq_coarse = 0;
	localparam int irq_fine = 1;
	localparam int irq_fll_rdy = 2;
	localparam int irq_pll_lock = 3;
	localparam int irq_pll_lost = 4;
	localparam int irq_ldrto = 5;
	localparam int irq_bits = 6;
	// default cycle counts
	localparam int sync_cycles = 3;
	localparam int settle_cycles = 4;
	localparam int fll_ready_cycles = 8;
	localparam int fll_coarse_cycles = 16;
	localparam int fll_fine_cycles = 32;
	localparam int pll_active_cycles = 8;
	localparam int pll_lock_cycles = 24;
	localparam int ratio_cycles = 6;
	// start delay software waits after output active, in ms, and in cycles at 125 MHz
	localparam int start_delay_ms = 10;
	localparam longint start_delay_cycles = longint'(start_delay_ms) * 125000;
endpackage

// ---- src/fll_pll_lock_status_control.sv ----
// Purpose: lock and status logic for the frequency-locked and phase-locked loops
// Assumes: loops modelled by cycle counters in the bus clock domain
// Notes: registers reached over a plain address/strobe port, read data one cycle later
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
module fll_pll_lock_status_control #(
	parameter int sync_cyc = osc_lock_pkg::sync_cycles,
	parameter int settle_cyc = osc_lock_pkg::settle_cycles,
	parameter int fll_ready_cyc = osc_lock_pkg::fll_ready_cycles,
	parameter int fll_coarse_cyc = osc_lock_pkg::fll_coarse_cycles,
	parameter int fll_fine_cyc = osc_lock_pkg::fll_fine_cycles,
	parameter int pll_active_cyc = osc_lock_pkg::pll_active_cycles,
	parameter int pll_lock_cyc = osc_lock_pkg::pll_lock_cycles,
	parameter int ratio_cyc = osc_lock_pkg::ratio_cycles
)(
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic [7:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic rd,
	input wire logic pll_lock_glitch, // asynchronous reference disturbance
	output logic [31:0] rdata,
	output logic irq,
	output logic fll_clk_en, // frequency loop output gate
	output logic pll_clk_en // phase loop output gate
);
////////////////////////////////////////////////////////////////////////////////
	// complete state of the block
	typedef struct packed {
		logic glitch_s1; // first sync stage
		logic glitch_s2; // second sync stage
		logic fll_en_req; // enable as written
		logic [3:0] sync_cnt; // enable synchronisation busy
		logic fll_en; // enable as applied
		logic fll_mode; // closed loop when set
		logic lose_lock_after_wake; // keep lock state across a disable
		logic [15:0] fll_mul;
		logic [15:0] fll_val;
		logic [7:0] fll_cnt; // acquisition progress
		logic [3:0] settle_cnt; // config settling window
		logic fll_ready;
		logic coarse;
		logic fine;
		logic locked;
		logic corrupt; // controller corrupted
		logic pll_en;
		logic lock_bypass; // output not gated by lock
		logic wake_up_fast; // output passes before first lock
		logic [15:0] pll_ratio;
		logic [7:0] pll_cnt;
		logic pll_rdy; // output activity seen
		logic pll_lock;
		logic seen_lock; // lock reached once since enable
		logic [3:0] ratio_cnt; // ratio update in progress
		logic ratio_run; // update began while running
		logic ldrto; // status done flag
		logic [5:0] intflag;
		logic [5:0] intmask;
		logic [31:0] rdata;
		logic irq;
		logic fll_clk_en;
		logic pll_clk_en;
	} state_t;

	state_t s; // registered state
	state_t next_s; // next state
	logic [5:0] ev; // one-cycle events
	logic wr_cfg; // write to a config register
	logic fll_stopped; // loop fully stopped

	assign rdata = s.rdata;
	assign irq = s.irq;
	assign fll_clk_en = s.fll_clk_en;
	assign pll_clk_en = s.pll_clk_en;
////////////////////////////////////////////////////////////////////////////////
	// next state logic
	always_comb
	begin
		next_s = s;
		ev = '0;
		// glitch input crosses in through two stages
		next_s.glitch_s1 = pll_lock_glitch;
		next_s.glitch_s2 = s.glitch_s1;
		wr_cfg = wr && (addr == osc_lock_pkg::fll_control_first || addr == osc_lock_pkg::fll_control_second
			|| addr == osc_lock_pkg::fll_multiplier || addr == osc_lock_pkg::fll_value_reg);
		fll_stopped = !s.fll_en && s.sync_cnt == 4'h0 && !s.fll_ready;

		// enable synchronisation countdown
		if (s.sync_cnt != 4'h0)
		begin
			next_s.sync_cnt = s.sync_cnt - 4'h1;
			if (s.sync_cnt == 4'h1)
				next_s.fll_en = s.fll_en_req;
		end
		// settling window after config writes
		if (s.settle_cnt != 4'h0)
			next_s.settle_cnt = s.settle_cnt - 4'h1;

		// software-side clears, hardware sets below win
		if (wr && addr == osc_lock_pkg::fll_status_reg)
		begin
			if (wdata[osc_lock_pkg::fst_coarse])
				next_s.coarse = 1'b0;
			if (wdata[osc_lock_pkg::fst_fine])
				next_s.fine = 1'b0;
			if (wdata[osc_lock_pkg::fst_locked])
				next_s.locked = 1'b0;
		end
		if (wr && addr == osc_lock_pkg::pll_status_reg && wdata[osc_lock_pkg::pst_ldrto])
			next_s.ldrto = 1'b0;
		if (wr && addr == osc_lock_pkg::int_flag_reg)
			next_s.intflag = s.intflag & ~wdata[5:0];

		// register writes
		if (wr)
		begin
			case (addr)
				osc_lock_pkg::fll_control_first:
				begin
					next_s.fll_en_req = wdata[osc_lock_pkg::ctl_enable];
					next_s.sync_cnt = 4'(sync_cyc);
				end
				osc_lock_pkg::fll_control_second:
				begin
					next_s.fll_mode = wdata[osc_lock_pkg::ctl_mode];
					next_s.lose_lock_after_wake = wdata[osc_lock_pkg::ctl_lose_lock_after_wake];
					// wake option changed while not stopped
					if (wdata[osc_lock_pkg::ctl_lose_lock_after_wake] != s.lose_lock_after_wake
						&& !fll_stopped)
						next_s.corrupt = 1'b1;
					// clearing mode resets lock flags
					if (!wdata[osc_lock_pkg::ctl_mode])
					begin
						next_s.coarse = 1'b0;
						next_s.fine = 1'b0;
						next_s.locked = 1'b0;
						if (fll_stopped)
							next_s.corrupt = 1'b0;
					end
				end
				osc_lock_pkg::fll_multiplier: next_s.fll_mul = wdata[15:0];
				osc_lock_pkg::fll_value_reg: next_s.fll_val = wdata[15:0];
				osc_lock_pkg::pll_control_first: next_s.pll_en = wdata[osc_lock_pkg::ctl_enable];
				osc_lock_pkg::pll_control_second:
				begin
					next_s.lock_bypass = wdata[osc_lock_pkg::ctl_lock_bypass];
					next_s.wake_up_fast = wdata[osc_lock_pkg::ctl_wake_up_fast];
				end
				osc_lock_pkg::pll_ratio_reg:
				begin
					next_s.pll_ratio = wdata[15:0];
					next_s.ratio_cnt = 4'(ratio_cyc);
					next_s.ratio_run = s.pll_en;
					next_s.ldrto = 1'b0;
				end
				osc_lock_pkg::int_mask_reg: next_s.intmask = wdata[5:0];
				default: ; // unmapped or flag-only writes
			endcase
		end
		// config write restarts acquisition, flags unsettled
		if (wr_cfg)
		begin
			next_s.settle_cnt = 4'(settle_cyc);
			next_s.fll_cnt = 8'h00;
		end

		// frequency loop acquisition
		if (s.fll_en)
		begin
			if (s.settle_cnt == 4'h0 && !wr_cfg && s.fll_cnt != 8'hff)
				next_s.fll_cnt = s.fll_cnt + 8'h01;
			if (s.fll_cnt >= 8'(fll_ready_cyc) && !s.fll_ready)
			begin
				next_s.fll_ready = 1'b1;
				ev[osc_lock_pkg::irq_fll_rdy] = 1'b1;
			end
			if (s.fll_mode && s.fll_cnt >= 8'(fll_coarse_cyc) && !s.coarse)
			begin
				next_s.coarse = 1'b1;
				ev[osc_lock_pkg::irq_coarse] = 1'b1;
			end
			if (s.fll_mode && s.fll_cnt >= 8'(fll_fine_cyc) && !s.fine && !s.corrupt)
			begin
				next_s.fine = 1'b1;
				next_s.locked = 1'b1;
				ev[osc_lock_pkg::irq_fine] = 1'b1;
			end
		end
		else
		begin
			next_s.fll_cnt = 8'h00;
			next_s.fll_ready = 1'b0;
			// locked drops on disable unless wake option held
			if (!s.lose_lock_after_wake)
				next_s.locked = 1'b0;
			// coarse and fine deliberately left as they are
			// until software clears the mode bit
		end
		// corrupt controller holds a stale lock and no fine lock,
		// unless a clearing mode write lands in this very cycle while the loop is stopped
		if (s.corrupt && next_s.corrupt)
		begin
			next_s.fine = 1'b0;
			next_s.locked = 1'b1;
		end

		// phase loop progress
		if (s.pll_en)
		begin
			if (s.pll_cnt != 8'hff)
				next_s.pll_cnt = s.pll_cnt + 8'h01;
			// ready from activity alone, lock not consulted
			if (s.pll_cnt >= 8'(pll_active_cyc))
				next_s.pll_rdy = 1'b1;
			if (s.pll_cnt >= 8'(pll_lock_cyc) && !s.glitch_s2)
			begin
				next_s.pll_lock = 1'b1;
				next_s.seen_lock = 1'b1;
				if (!s.pll_lock)
					ev[osc_lock_pkg::irq_pll_lock] = 1'b1;
			end
			// disturbance drops lock though output is stable
			if (s.glitch_s2 && s.pll_lock)
			begin
				next_s.pll_lock = 1'b0;
				ev[osc_lock_pkg::irq_pll_lost] = 1'b1;
			end
		end
		else
		begin
			next_s.pll_cnt = 8'h00;
			next_s.pll_rdy = 1'b0;
			next_s.pll_lock = 1'b0;
			next_s.seen_lock = 1'b0;
		end

		// ratio update completion
		if (s.ratio_cnt != 4'h0 && !(wr && addr == osc_lock_pkg::pll_ratio_reg))
		begin
			next_s.ratio_cnt = s.ratio_cnt - 4'h1;
			if (s.ratio_cnt == 4'h1)
			begin
				ev[osc_lock_pkg::irq_ldrto] = 1'b1;
				if (!s.ratio_run)
					next_s.ldrto = 1'b1;
			end
		end

		// sticky flags, set beats clear
		next_s.intflag = next_s.intflag | ev;
		next_s.irq = |(next_s.intflag & next_s.intmask);

		// output gating, bypass ignores lock state
		next_s.fll_clk_en = s.fll_en && s.fll_ready;
		next_s.pll_clk_en = s.pll_en && s.pll_rdy
			&& (s.pll_lock || s.lock_bypass || (s.wake_up_fast && !s.seen_lock));

		// read data for one cycle only
		next_s.rdata = 32'h0000_0000;
		if (rd)
		begin
			case (addr)
				osc_lock_pkg::fll_control_first: next_s.rdata = {31'h0, s.fll_en_req};
				osc_lock_pkg::fll_control_second: next_s.rdata = {30'h0, s.lose_lock_after_wake, s.fll_mode};
				osc_lock_pkg::fll_multiplier: next_s.rdata = {16'h0000, s.fll_mul};
				osc_lock_pkg::fll_value_reg: next_s.rdata = {16'h0000, s.fll_val};
				osc_lock_pkg::fll_status_reg:
					next_s.rdata = {25'h0, s.corrupt, s.settle_cnt != 4'h0, s.sync_cnt != 4'h0,
						s.locked, s.fine, s.coarse, s.fll_ready};
				osc_lock_pkg::pll_control_first: next_s.rdata = {31'h0, s.pll_en};
				osc_lock_pkg::pll_control_second: next_s.rdata = {30'h0, s.wake_up_fast, s.lock_bypass};
				osc_lock_pkg::pll_ratio_reg: next_s.rdata = {16'h0000, s.pll_ratio};
				osc_lock_pkg::pll_status_reg: next_s.rdata = {29'h0, s.ldrto, s.pll_lock, s.pll_rdy};
				osc_lock_pkg::int_flag_reg: next_s.rdata = {26'h0, s.intflag};
				osc_lock_pkg::int_mask_reg: next_s.rdata = {26'h0, s.intmask};
				default: next_s.rdata = 32'h0000_0000; // unmapped reads zero
			endcase
		end
	end
////////////////////////////////////////////////////////////////////////////////
	// state register, synchronous reset
	always_ff @(posedge clk_sys)
	begin
		if (rst)
			s <= '0;
		else
			s <= next_s;
	end
////////////////////////////////////////////////////////////////////////////////
	// checks on the block's own behaviour
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	sequence s_ratio_finish;
		s.ratio_cnt == 4'h1 && s.ratio_run && !(wr && addr == osc_lock_pkg::pll_ratio_reg);
	endsequence

	property p_wake_hold;
		(s.lose_lock_after_wake && s.locked && !s.fll_en && !wr) |=> s.locked;
	endproperty
	a_wake_hold: assert property (p_wake_hold) else $error("locked dropped with wake option set");

	property p_flags_kept;
		(s.fll_mode && !s.fll_en && s.fine && s.coarse && !s.corrupt && !wr) |=> (s.fine && s.coarse);
	endproperty
	a_flags_kept: assert property (p_flags_kept) else $error("lock flags cleared by disable");

	property p_settle;
		wr_cfg |=> s.settle_cnt == 4'(settle_cyc) && s.fll_cnt == 8'h00;
	endproperty
	a_settle: assert property (p_settle) else $error("config write did not restart settling");

	property p_corrupt;
		(wr && addr == osc_lock_pkg::fll_control_second
			&& wdata[osc_lock_pkg::ctl_lose_lock_after_wake] != s.lose_lock_after_wake
			&& s.fll_en) |=> s.corrupt ##1 s.locked;
	endproperty
	a_corrupt: assert property (p_corrupt) else $error("running wake change not flagged");

	property p_false_unlock;
		(s.glitch_s2 && s.pll_lock && s.pll_en) |=> !s.pll_lock && s.intflag[osc_lock_pkg::irq_pll_lost];
	endproperty
	a_false_unlock: assert property (p_false_unlock) else $error("lock kept through disturbance");

	property p_bypass;
		(s.lock_bypass && s.pll_en && s.pll_rdy) |=> pll_clk_en;
	endproperty
	a_bypass: assert property (p_bypass) else $error("output gated under bypass");

	property p_ready_activity;
		(s.pll_en && s.pll_rdy && s.glitch_s2 && !wr) |=> s.pll_rdy [*2];
	endproperty
	a_ready_activity: assert property (p_ready_activity) else $error("ready followed lock state");

	property p_ratio_fly;
		s_ratio_finish |=> !s.ldrto && s.intflag[osc_lock_pkg::irq_ldrto];
	endproperty
	a_ratio_fly: assert property (p_ratio_fly) else $error("on-the-fly ratio set status flag");

	property p_irq_level;
		|(s.intflag & s.intmask) |-> irq;
	endproperty
	a_irq_level: assert property (p_irq_level) else $error("interrupt low with unmasked flag");
endmodule // fll_pll_lock_status_control

// ---- test/fll_pll_lock_status_control_bench.sv ----
// Purpose: self-checking bench for the loop lock and status controller
// Assumes: default short count parameters, register map from the package
// Notes: the bench plays software and drives every input of the block itself
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
module fll_pll_lock_status_control_bench;
	logic clk_sys = 1'b0; // bus clock
	logic rst = 1'b1; // synchronous reset
	logic [7:0] addr = 8'h00; // register byte address
	logic [31:0] wdata = 32'h0; // write data
	logic wr = 1'b0; // write strobe
	logic rd = 1'b0; // read strobe
	logic pll_lock_glitch = 1'b0; // reference disturbance
	logic [31:0] rdata; // read data, one cycle after rd
	logic irq; // level interrupt
	logic fll_clk_en; // frequency loop output gate
	logic pll_clk_en; // phase loop output gate
	logic [31:0] s; // last value read
	int fail_count = 0; // mismatches
	int num_checks = 0; // comparisons made

	// 125 MHz
	always #4 clk_sys = ~clk_sys;

	fll_pll_lock_status_control DUT (
		.clk_sys(clk_sys),
		.rst(rst),
		.addr(addr),
		.wdata(wdata),
		.wr(wr),
		.rd(rd),
		.pll_lock_glitch(pll_lock_glitch),
		.rdata(rdata),
		.irq(irq),
		.fll_clk_en(fll_clk_en),
		.pll_clk_en(pll_clk_en)
	);

	////////////////////////////////////////////////////////////////////////////
	// compare seen against expected, four-state
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
		end
	endtask

	// one-cycle write strobe, released at the edge that takes it
	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk_sys);
		wr <= 1'b0;
	endtask

	// data stand only in the cycle after the strobe, so sample just past that edge
	task automatic rd_reg(input logic [7:0] a);
		@(posedge clk_sys);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk_sys);
		rd <= 1'b0;
		#1;
		s = rdata;
	endtask

	// bounded wait for one status bit, the final value is compared
	task automatic poll(input logic [7:0] a, input int b, input logic v);
		int n;
		n = 0;
		rd_reg(a);
		while (s[b] !== v && n < 200)
		begin
			rd_reg(a);
			n++;
		end
		check(32'(s[b]), 32'(v));
	endtask

	// single place where the run ends
	task automatic print_verdict();
		$display("checks=%0d mismatches=%0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////
	// watchdog, the tests need a few hundred cycles
	initial
	begin
		#(20000 * 8);
		fail_count++;
		print_verdict();
	end

	// main sequence
	initial
	begin
		repeat (16) @(posedge clk_sys);
		rst <= 1'b0;
		rd_reg(osc_lock_pkg::fll_status_reg);
		check(s, 32'h0);
		check({29'h0, irq, fll_clk_en, pll_clk_en}, 32'h0);
		$display("reset values done");
		// closed loop start, status cleared around the enable
		wr_reg(osc_lock_pkg::fll_control_second, 32'h1);
		wr_reg(osc_lock_pkg::fll_status_reg, 32'he);
		wr_reg(osc_lock_pkg::fll_control_first, 32'h1);
		wr_reg(osc_lock_pkg::fll_status_reg, 32'he);
		poll(osc_lock_pkg::fll_status_reg, osc_lock_pkg::fst_locked, 1'b1);
		check(32'(s[3:0]), 32'hf);
		check(32'(fll_clk_en), 32'h1);
		// disable: lock drops, coarse and fine stay behind
		wr_reg(osc_lock_pkg::fll_control_first, 32'h0);
		poll(osc_lock_pkg::fll_status_reg, osc_lock_pkg::fst_sync_busy, 1'b0);
		poll(osc_lock_pkg::fll_status_reg, osc_lock_pkg::fst_ready, 1'b0);
		check(32'(s[3:0]), 32'h6);
		check(32'(fll_clk_en), 32'h0);
		wr_reg(osc_lock_pkg::fll_control_second, 32'h0);
		rd_reg(osc_lock_pkg::fll_status_reg);
		check(32'(s[3:0]), 32'h0);
		$display("closed loop disable done");
		// wake option set while stopped, lock survives the disable
		wr_reg(osc_lock_pkg::fll_control_second, 32'h3);
		wr_reg(osc_lock_pkg::fll_control_first, 32'h1);
		poll(osc_lock_pkg::fll_status_reg, osc_lock_pkg::fst_locked, 1'b1);
		wr_reg(osc_lock_pkg::fll_control_first, 32'h0);
		poll(osc_lock_pkg::fll_status_reg, osc_lock_pkg::fst_sync_busy, 1'b0);
		poll(osc_lock_pkg::fll_status_reg, osc_lock_pkg::fst_ready, 1'b0);
		check(32'(s[6:0]), 32'he);
		wr_reg(osc_lock_pkg::fll_control_second, 32'h2);
		rd_reg(osc_lock_pkg::fll_status_reg);
		check(32'(s[6:0]), 32'h20);
		$display("wake option lock done");
		// a configuration write leaves the flags unsettled for a while
		wr_reg(osc_lock_pkg::fll_multiplier, 32'h0123);
		rd_reg(osc_lock_pkg::fll_status_reg);
		check(32'(s[5]), 32'h1);
		poll(osc_lock_pkg::fll_status_reg, osc_lock_pkg::fst_settling, 1'b0);
		// wake option changed while running corrupts the lock state
		wr_reg(osc_lock_pkg::fll_control_second, 32'h3);
		wr_reg(osc_lock_pkg::fll_control_first, 32'h1);
		poll(osc_lock_pkg::fll_status_reg, osc_lock_pkg::fst_ready, 1'b1);
		wr_reg(osc_lock_pkg::fll_control_second, 32'h1);
		rd_reg(osc_lock_pkg::fll_status_reg);
		check({29'h0, s[6], s[3], s[2]}, 32'h6);
		// proper stop order, then the mode write clears all but the settling flag
		wr_reg(osc_lock_pkg::fll_control_first, 32'h0);
		poll(osc_lock_pkg::fll_status_reg, osc_lock_pkg::fst_sync_busy, 1'b0);
		poll(osc_lock_pkg::fll_status_reg, osc_lock_pkg::fst_ready, 1'b0);
		wr_reg(osc_lock_pkg::fll_control_second, 32'h0);
		rd_reg(osc_lock_pkg::fll_status_reg);
		check(32'(s[6:0]), 32'h20);
		$display("corruption done");
		// phase loop start with bypass and fast wake
		wr_reg(osc_lock_pkg::pll_control_second, 32'h3);
		wr_reg(osc_lock_pkg::pll_control_first, 32'h1);
		poll(osc_lock_pkg::pll_status_reg, osc_lock_pkg::pst_active, 1'b1);
		check(32'(pll_clk_en), 32'h1);
		poll(osc_lock_pkg::pll_status_reg, osc_lock_pkg::pst_locked, 1'b1);
		@(posedge clk_sys);
		pll_lock_glitch <= 1'b1;
		repeat (6) @(posedge clk_sys);
		rd_reg(osc_lock_pkg::pll_status_reg);
		check(32'(s[2:0]), 32'h1);
		check(32'(pll_clk_en), 32'h1);
		// without bypass the lost lock gates the output
		wr_reg(osc_lock_pkg::pll_control_second, 32'h0);
		rd_reg(osc_lock_pkg::pll_status_reg);
		check(32'(pll_clk_en), 32'h0);
		@(posedge clk_sys);
		pll_lock_glitch <= 1'b0;
		poll(osc_lock_pkg::pll_status_reg, osc_lock_pkg::pst_locked, 1'b1);
		rd_reg(osc_lock_pkg::pll_status_reg);
		check(32'(pll_clk_en), 32'h1);
		$display("phase loop gating done");
		// ratio change on the fly: only the interrupt flag reports it
		wr_reg(osc_lock_pkg::int_mask_reg, 32'h20);
		wr_reg(osc_lock_pkg::int_flag_reg, 32'h3f);
		wr_reg(osc_lock_pkg::pll_ratio_reg, 32'h5);
		repeat (10) @(posedge clk_sys);
		rd_reg(osc_lock_pkg::pll_status_reg);
		check(32'(s[2]), 32'h0);
		rd_reg(osc_lock_pkg::int_flag_reg);
		check(32'(s[5]), 32'h1);
		check(32'(irq), 32'h1);
		wr_reg(osc_lock_pkg::int_flag_reg, 32'h20);
		rd_reg(osc_lock_pkg::int_flag_reg);
		check(32'(s[5]), 32'h0);
		check(32'(irq), 32'h0);
		// ratio written while stopped does raise the status flag
		wr_reg(osc_lock_pkg::pll_control_first, 32'h0);
		wr_reg(osc_lock_pkg::pll_ratio_reg, 32'h7);
		repeat (10) @(posedge clk_sys);
		rd_reg(osc_lock_pkg::pll_status_reg);
		check(32'(s[2]), 32'h1);
		check(32'(irq), 32'h1);
		wr_reg(osc_lock_pkg::int_mask_reg, 32'h0);
		wr_reg(osc_lock_pkg::pll_status_reg, 32'h4);
		rd_reg(osc_lock_pkg::pll_status_reg);
		check(32'(s[2]), 32'h0);
		check(32'(irq), 32'h0);
		$display("ratio update done");
		// fast wake alone: output passes before the first lock, gated once lock is lost
		wr_reg(osc_lock_pkg::pll_control_second, 32'h2);
		wr_reg(osc_lock_pkg::pll_control_first, 32'h1);
		poll(osc_lock_pkg::pll_status_reg, osc_lock_pkg::pst_active, 1'b1);
		check(32'(pll_clk_en), 32'h1);
		poll(osc_lock_pkg::pll_status_reg, osc_lock_pkg::pst_locked, 1'b1);
		@(posedge clk_sys);
		pll_lock_glitch <= 1'b1;
		repeat (6) @(posedge clk_sys);
		rd_reg(osc_lock_pkg::pll_status_reg);
		check(32'(s[2:0]), 32'h1);
		check(32'(pll_clk_en), 32'h0);
		$display("fast wake gating done");
		// unmapped place reads zero and a write there changes nothing
		wr_reg(8'hfc, 32'hffff_ffff);
		rd_reg(8'hfc);
		check(s, 32'h0);
		rd_reg(osc_lock_pkg::int_mask_reg);
		check(s, 32'h0);
		$display("unmapped access done");
		print_verdict();
	end
endmodule // fll_pll_lock_status_control_bench
